// *** core/ldc_capture.sv ***
// ddr capture of one 12-lane bus with marker-based fifo alignment
module ldc_capture #(
	parameter int LANES = ldc_pkg::LANES,
	parameter int DEPTH = ldc_pkg::FIFO_DEPTH
) (
	// sample clock domain
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    ce_i,
	// configuration, sample clock domain
	input  wire logic                    lane_marker_sel_i,
	input  wire logic [ldc_pkg::RES_W-1:0] lane_resolution_i,
	// link pins
	input  wire logic                    bus_d_forwarded_clock_i,
	input  wire logic                    link_rst_n_i,
	input  wire logic [LANES-1:0]        bus_d_data_lane_i,
	input  wire logic                    bus_d_marker_lane_i,
	// sample output
	output logic                         sample_valid_o,
	input  wire logic                    sample_ready_i,
	output logic [LANES-1:0]             sample_data_o,
	output logic                         sample_marker_o,
	output logic                         link_overflow_o
);
	localparam int W = LANES + 1;
	// rising and falling half-samples
	logic [LANES-1:0] rise_d;
	logic             rise_m;
	logic [LANES-1:0] fall_d;
	logic             fall_m;
	logic [W-1:0]     wq_data;
	logic             wq_valid;
	logic             wready;
	logic             sel_s1;
	logic             sel_s2;
	logic [ldc_pkg::RES_W-1:0] res_s1;
	logic [ldc_pkg::RES_W-1:0] res_s2;
	logic             ovf;
	logic             seen_mark;
	logic             rvalid;
	logic [W-1:0]     rdata;
	logic             next_valid;
	logic [W-1:0]     next_hold;
	logic [W-1:0]     hold;
	logic             mark_sel;
	// counts link rises since reset until the config sync is valid
	logic [1:0]       settle;
	logic             cfg_ok;

	// marks seen before both sync stages hold the config are untrusted
	assign cfg_ok = (settle == 2'd2);

	always_ff @(negedge bus_d_forwarded_clock_i) begin
		fall_d <= bus_d_data_lane_i;
		fall_m <= bus_d_marker_lane_i;
	end

	always_ff @(posedge bus_d_forwarded_clock_i) begin
		rise_d <= bus_d_data_lane_i;
		rise_m <= bus_d_marker_lane_i;
	end

	// config into link domain, quasi-static
	always_ff @(posedge bus_d_forwarded_clock_i) begin
		if (!link_rst_n_i) begin
			sel_s1 <= 1'b0;
			sel_s2 <= 1'b0;
			res_s1 <= ldc_pkg::RES_RST;
			res_s2 <= ldc_pkg::RES_RST;
		end else begin
			sel_s1 <= lane_marker_sel_i;
			sel_s2 <= sel_s1;
			res_s1 <= lane_resolution_i;
			res_s2 <= res_s1;
		end
	end

	function automatic logic pick_marker(input logic [LANES-1:0] d,
		input logic m, input logic sel, input logic [3:0] res);
		int idx;
		idx = ldc_pkg::MARKER_BASE - int'(res);
		if (sel && idx >= 0 && idx < LANES)
			return d[idx];
		return m;
	endfunction

	assign mark_sel = pick_marker(rise_d, rise_m, sel_s2, res_s2);

	// only the rising half is a sample; the falling half is captured but never written
	always_ff @(posedge bus_d_forwarded_clock_i) begin
		if (!link_rst_n_i) begin
			wq_valid  <= 1'b0;
			wq_data   <= '0;
			seen_mark <= 1'b0;
			ovf       <= 1'b0;
			settle    <= 2'd0;
		end else begin
			if (!cfg_ok)
				settle <= settle + 2'd1;
			// writes held back until marker fixes slot
			wq_valid <= seen_mark || (mark_sel && cfg_ok);
			wq_data  <= {mark_sel, rise_d};
			if (mark_sel && cfg_ok)
				seen_mark <= 1'b1;
			if (wq_valid && !wready)
				ovf <= 1'b1;
		end
	end

	ldc_fifo #(
		.WIDTH (W),
		.DEPTH (DEPTH)
	) u_fifo (
		.wclk_i   (bus_d_forwarded_clock_i),
		.wrst_n_i (link_rst_n_i),
		.wvalid_i (wq_valid),
		.wready_o (wready),
		.wdata_i  (wq_data),
		.rclk_i   (clk_i),
		.rrst_n_i (rst_n_i),
		.rce_i    (ce_i && (!sample_valid_o || sample_ready_i)),
		.rvalid_o (rvalid),
		.rready_i (1'b1),
		.rdata_o  (rdata)
	);

	logic ovf_s1;
	logic ovf_s2;

	always_comb begin
		next_valid = sample_valid_o;
		next_hold  = hold;
		if (!sample_valid_o || sample_ready_i) begin
			next_valid = rvalid;
			next_hold  = rdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sample_valid_o  <= 1'b0;
			hold            <= '0;
			ovf_s1          <= 1'b0;
			ovf_s2          <= 1'b0;
			link_overflow_o <= 1'b0;
		end else if (ce_i) begin
			sample_valid_o  <= next_valid;
			hold            <= next_hold;
			ovf_s1          <= ovf;
			ovf_s2          <= ovf_s1;
			link_overflow_o <= ovf_s2;
		end
	end

	assign sample_data_o   = hold[LANES-1:0];
	assign sample_marker_o = hold[LANES];

	// consumer holds off an offered sample
	sequence stall_s;
		ce_i && sample_valid_o && !sample_ready_i;
	endsequence

	// first link write after link reset
	sequence first_write_s;
		wq_valid && !$past(seen_mark);
	endsequence

	// output holds while stalled
	hold_stable_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		stall_s |=> $stable(hold))
		else $error("sample changed while stalled");

	// offer is not withdrawn while stalled
	valid_hold_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		stall_s |=> sample_valid_o)
		else $error("valid dropped while stalled");

	// overflow flag is sticky on the sample side
	out_ovf_sticky_a: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		link_overflow_o |=> link_overflow_o)
		else $error("overflow flag cleared without reset");

	// alignment is only set after a marked sample
	mark_first_a: assert property (
		@(posedge bus_d_forwarded_clock_i) disable iff (!link_rst_n_i)
		$rose(seen_mark) |-> $past(mark_sel))
		else $error("alignment without marker");

	// the word that opens the stream carries the marker bit
	first_mark_a: assert property (
		@(posedge bus_d_forwarded_clock_i) disable iff (!link_rst_n_i)
		first_write_s |-> wq_data[LANES])
		else $error("first write lacks marker");

	// once aligned, every link rise writes
	stream_on_a: assert property (
		@(posedge bus_d_forwarded_clock_i) disable iff (!link_rst_n_i)
		seen_mark |=> wq_valid)
		else $error("gap in aligned stream");

	// link side overflow is sticky until link reset
	ovf_sticky_a: assert property (
		@(posedge bus_d_forwarded_clock_i) disable iff (!link_rst_n_i)
		ovf |=> ovf)
		else $error("link overflow cleared without reset");

	// lane mode takes the marker from the chosen data lane
	lane_pick_a: assert property (
		@(posedge bus_d_forwarded_clock_i) disable iff (!link_rst_n_i)
		sel_s2 && ((ldc_pkg::MARKER_BASE - int'(res_s2)) inside
			{[0:LANES-1]}) |->
		mark_sel == rise_d[ldc_pkg::MARKER_BASE - int'(res_s2)])
		else $error("marker not taken from data lane");

	// dedicated lane marker rides the same bus clock
	strobe_lane_a: assert property (
		@(posedge bus_d_forwarded_clock_i) disable iff (!link_rst_n_i)
		!sel_s2 |-> mark_sel == rise_m)
		else $error("marker not taken from marker lane");
endmodule

// *** core/ldc_fifo.sv ***
// dual-clock fifo with gray pointers
module ldc_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 16
) (
	// write side, link clock
	input  wire logic             wclk_i,
	input  wire logic             wrst_n_i,
	input  wire logic             wvalid_i,
	output logic                  wready_o,
	input  wire logic [WIDTH-1:0] wdata_i,
	// read side, sample clock
	input  wire logic             rclk_i,
	input  wire logic             rrst_n_i,
	input  wire logic             rce_i,
	output logic                  rvalid_o,
	input  wire logic             rready_i,
	output logic [WIDTH-1:0]      rdata_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wbin;
	logic [AW:0]      wgray;
	logic [AW:0]      rbin;
	logic [AW:0]      rgray;
	logic [AW:0]      rg_s1;
	logic [AW:0]      rg_s2;
	logic [AW:0]      wg_s1;
	logic [AW:0]      wg_s2;
	logic [AW:0]      next_wbin;
	logic [AW:0]      next_rbin;
	logic             wr_en;
	logic             rd_en;

	assign wready_o = (wgray != {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
	assign rvalid_o = (rgray != wg_s2);
	assign rdata_o  = mem[rbin[AW-1:0]];
	assign wr_en    = wvalid_i && wready_o;
	assign rd_en    = rce_i && rvalid_o && rready_i;

	always_comb begin
		next_wbin = wr_en ? wbin + 1'b1 : wbin;
		next_rbin = rd_en ? rbin + 1'b1 : rbin;
	end

	always_ff @(posedge wclk_i) begin
		if (!wrst_n_i) begin
			wbin  <= '0;
			wgray <= '0;
			rg_s1 <= '0;
			rg_s2 <= '0;
		end else begin
			if (wr_en)
				mem[wbin[AW-1:0]] <= wdata_i;
			wbin  <= next_wbin;
			wgray <= next_wbin ^ (next_wbin >> 1);
			rg_s1 <= rgray;
			rg_s2 <= rg_s1;
		end
	end

	always_ff @(posedge rclk_i) begin
		if (!rrst_n_i) begin
			rbin  <= '0;
			rgray <= '0;
			wg_s1 <= '0;
			wg_s2 <= '0;
		end else if (rce_i) begin
			rbin  <= next_rbin;
			rgray <= next_rbin ^ (next_rbin >> 1);
			wg_s1 <= wgray;
			wg_s2 <= wg_s1;
		end
	end
endmodule

// *** core/ldc_pkg.sv ***
// constants shared by the bus capture block and its fifo
package ldc_pkg;
	localparam int LANES        = 12;
	localparam int FIFO_DEPTH   = 16;
	localparam int MARKER_BASE  = 12;
	localparam int RES_W        = 4;
	localparam logic [3:0] RES_RST = 4'h0;
	localparam int FIFO_SLOT    = 0;
endpackage

// *** verif/ldc_tx_model.sv ***
// transmitter model driving the ddr bus with a counting pattern
module ldc_tx_model (
	input  wire logic        run_i,
	input  wire logic        rst_n_i,
	input  wire logic        sel_i,
	input  wire logic [3:0]  res_i,
	input  wire logic [11:0] base_i,
	output logic             lclk_o,
	output logic [11:0]      d_o,
	output logic             mk_o
);
	timeunit 1ns;
	timeprecision 1ps;
	int k = 0;
	initial begin
		lclk_o = 0;
		#3;
		forever begin
			#15;
			if (run_i) lclk_o = ~lclk_o;
		end
	end
	// one marked sample, lane or dedicated
	always @(negedge lclk_o) begin
		k = rst_n_i ? k + 1 : 0;
		d_o = base_i + 12'(k);
		mk_o = (k == 4);
		if (sel_i && res_i inside {[1:12]}) begin
			mk_o = k[0];
			d_o[12 - res_i] = (k == 4);
		end
	end
	// released lines show the inverse
	always @(negedge run_i) d_o = ~d_o;
endmodule

// *** verif/tb.sv ***
// bench: random frames through the capture block, then a stall
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 0, rst_n_i = 0, lrst = 0, run = 0, sel = 0, rdy = 0;
	logic [3:0]  res = 0;
	logic [11:0] base = 0;
	logic        lclk, mk, vld, smk, ovf;
	logic [11:0] d, sd;
	int          bad_count = 0, checks = 0, cyc = 0;
	logic [3:0]  rl[5] = '{4'h0, 4'h1, 4'h6, 4'hC, 4'hF};

	always #5 clk_i = ~clk_i;

	ldc_tx_model u_tx (.run_i(run), .rst_n_i(lrst), .sel_i(sel),
		.res_i(res), .base_i(base), .lclk_o(lclk), .d_o(d), .mk_o(mk));

	ldc_capture u_dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.lane_marker_sel_i(sel), .lane_resolution_i(res),
		.bus_d_forwarded_clock_i(lclk), .link_rst_n_i(lrst),
		.bus_d_data_lane_i(d), .bus_d_marker_lane_i(mk),
		.sample_valid_o(vld), .sample_ready_i(rdy),
		.sample_data_o(sd), .sample_marker_o(smk),
		.link_overflow_o(ovf));

	task automatic check(input logic [12:0] seen, input logic [12:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	function automatic logic [11:0] exp_word(int k);
		logic [11:0] w;
		w = base + 12'(k);
		if (sel && res inside {[1:12]})
			w[12 - res] = (k == 4);
		return w;
	endfunction

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic frame(input logic s, input logic [3:0] r, input bit stl);
		int j;
		j = 0;
		@(posedge clk_i);
		rst_n_i <= 0;
		lrst <= 0;
		run <= 1;
		sel <= s;
		res <= r;
		rdy <= 0;
		base <= 12'($urandom);
		repeat (12) @(posedge clk_i);
		rst_n_i <= 1;
		lrst <= 1;
		while (!stl && j < 20) begin
			@(negedge clk_i);
			if (vld === 1'b1 && rdy === 1'b1) begin
				check({smk, sd}, {j == 0, exp_word(j + 4)});
				j++;
			end
			@(posedge clk_i);
			rdy <= 1'($urandom);
		end
		if (!stl)
			rdy <= 1'b1;
		repeat (150) @(posedge clk_i);
		check({12'h0, ovf}, {12'h0, stl});
		run <= 0;
		$display("frame sel %0d res %0d stall %0d done", s, r, stl);
	endtask

	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	initial begin
		void'($urandom(76927));
		foreach (rl[i]) frame(1'b1, rl[i], 0);
		repeat (4) frame(1'($urandom), 4'($urandom), 0);
		frame(1'b0, 4'h3, 1);
		complete_run();
	end
endmodule
